/* File: rtl/rmrc_regs.sv */
`timescale 1ns/1ps
module rmrc_regs (
    input wire logic ref_clk_i, // 250 MHz clock
    input wire logic reset_n_i, // async active-low reset
    input wire logic [5:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [31:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte enables
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall
    output logic [1:0] modulation_select_o, // 10 fsk, 01 ook
    output logic [1:0] data_mode_o, // 00 cont, 01 buf, 10 packet
    output logic [1:0] onoff_threshold_type_o, // demod threshold
    output logic [1:0] intermediate_gain_step_o, // if gain step
    output logic mod_reserved_o, // reserved modulation code held
    output logic [7:0] deviation_value_o, // deviation divisor
    output logic [6:0] rate_value_o, // bit-rate divisor
    output logic [7:0] onoff_floor_value_o // floor, 0.5 db steps
);
    logic rst_s1_q;
    logic rst_s2_q;
    logic [7:0] dmod_q, dmod_d;
    logic [7:0] fdev_q, fdev_d;
    logic [7:0] rate_q, rate_d;
    logic [7:0] floor_q, floor_d;
    logic ack_q, ack_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] mod_q, mod_d;
    logic [1:0] dm_q, dm_d;
    logic [1:0] thr_q, thr_d;
    logic [1:0] gain_q, gain_d;
    logic modres_q, modres_d;
    logic [3:0] idx;
    logic hit;
    logic req;

    // release reset through two flops
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign idx = avs_address_i[5:2];
    assign req = (avs_read_i | avs_write_i) & ~ack_q;
    assign hit = (idx == rmrc_pkg::RMRC_IDX_DMOD) | (idx == rmrc_pkg::RMRC_IDX_FDEV)
               | (idx == rmrc_pkg::RMRC_IDX_RATE) | (idx == rmrc_pkg::RMRC_IDX_FLOOR);

    // one wait state: accept while ack is low, then raise it for one cycle
    always_comb begin
        logic wr;
        wr = avs_write_i & req & avs_byteenable_i[0];
        dmod_d = dmod_q;
        fdev_d = fdev_q;
        rate_d = rate_q;
        floor_d = floor_q;
        ack_d = req;
        // registered stall so the port comes straight from a flop
        wait_d = ~req;
        rdata_d = rdata_q;
        if (wr) begin
            unique case (idx)
                rmrc_pkg::RMRC_IDX_DMOD: dmod_d = avs_writedata_i[7:0];
                rmrc_pkg::RMRC_IDX_FDEV: fdev_d = avs_writedata_i[7:0];
                rmrc_pkg::RMRC_IDX_RATE: rate_d = avs_writedata_i[7:0] & rmrc_pkg::RMRC_RATE_WMASK;
                rmrc_pkg::RMRC_IDX_FLOOR: floor_d = avs_writedata_i[7:0];
                default: ;
            endcase
        end
        if (avs_read_i & req) begin
            rdata_d = rmrc_pkg::RMRC_BAD_ADDR_DATA;
            unique case (idx)
                rmrc_pkg::RMRC_IDX_DMOD: rdata_d[7:0] = dmod_q;
                rmrc_pkg::RMRC_IDX_FDEV: rdata_d[7:0] = fdev_q;
                rmrc_pkg::RMRC_IDX_RATE: rdata_d[7:0] = rate_q;
                rmrc_pkg::RMRC_IDX_FLOOR: rdata_d[7:0] = floor_q;
                default: ;
            endcase
        end
        if (!hit && avs_read_i && req) begin
            rdata_d = rmrc_pkg::RMRC_BAD_ADDR_DATA;
        end
    end

    // decode fields onto outputs, one cycle after the register
    always_comb begin
        mod_d = dmod_q[rmrc_pkg::RMRC_MOD_HI:rmrc_pkg::RMRC_MOD_LO];
        modres_d = (mod_d != rmrc_pkg::RMRC_MOD_FSK) && (mod_d != rmrc_pkg::RMRC_MOD_OOK);
        if (dmod_q[rmrc_pkg::RMRC_DM_HIGH_BIT]) begin
            dm_d = rmrc_pkg::RMRC_DMODE_PKT;
        end else if (dmod_q[rmrc_pkg::RMRC_DM_LOW_BIT]) begin
            dm_d = rmrc_pkg::RMRC_DMODE_BUF;
        end else begin
            dm_d = rmrc_pkg::RMRC_DMODE_CONT;
        end
        thr_d = dmod_q[rmrc_pkg::RMRC_THR_HI:rmrc_pkg::RMRC_THR_LO];
        gain_d = dmod_q[rmrc_pkg::RMRC_GAIN_HI:rmrc_pkg::RMRC_GAIN_LO];
    end

    always_ff @(posedge ref_clk_i or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            dmod_q <= rmrc_pkg::RMRC_RST_DMOD;
            fdev_q <= rmrc_pkg::RMRC_RST_FDEV;
            rate_q <= rmrc_pkg::RMRC_RST_RATE;
            floor_q <= rmrc_pkg::RMRC_RST_FLOOR;
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            mod_q <= rmrc_pkg::RMRC_MOD_FSK;
            dm_q <= rmrc_pkg::RMRC_DMODE_CONT;
            thr_q <= rmrc_pkg::RMRC_THR_PEAK;
            gain_q <= 2'h0;
            modres_q <= 1'b0;
        end else begin
            dmod_q <= dmod_d;
            fdev_q <= fdev_d;
            rate_q <= rate_d;
            floor_q <= floor_d;
            ack_q <= ack_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            mod_q <= mod_d;
            dm_q <= dm_d;
            thr_q <= thr_d;
            gain_q <= gain_d;
            modres_q <= modres_d;
        end
    end

    // waitrequest high except in the acknowledge cycle
    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;
    assign modulation_select_o = mod_q;
    assign data_mode_o = dm_q;
    assign onoff_threshold_type_o = thr_q;
    assign intermediate_gain_step_o = gain_q;
    assign mod_reserved_o = modres_q;
    assign deviation_value_o = fdev_q;
    assign rate_value_o = rate_q[6:0];
    assign onoff_floor_value_o = floor_q;
endmodule

/* File: rtl/rmrc_pkg.sv */
// How it works
// - bits 7-6 pick modulation: 10 frequency-shift (reset), 01 on-off, others reserved.
// - data mode from bit 2 high, bit 5 low: 00 continuous, 01 buffered, 1x packet.
// - bits 4-3 pick on-off threshold: 00 fixed, 01 peak (reset), 10 average.
// - bits 1-0 pick IF gain: 0, -4.5, -9, -13.5 dB; reset is maximum.
// - eight-bit deviation gives fdev equal to crystal over 32 times value plus one.
// - seven-bit rate gives crystal over 64 times value plus one; reset 7 is 25 kbps.
// - eight-bit on-off floor in 0.5 dB steps, reset 12 meaning 6 dB.
// - rate figures refer to a 12.8 MHz crystal and scale with other crystals.
package rmrc_pkg;
    localparam int unsigned RMRC_ADDR_W = 4;
    localparam int unsigned RMRC_DATA_W = 8;
    // byte addresses: word index times four
    localparam logic [RMRC_ADDR_W-1:0] RMRC_IDX_DMOD = 4'h1;
    localparam logic [RMRC_ADDR_W-1:0] RMRC_IDX_FDEV = 4'h2;
    localparam logic [RMRC_ADDR_W-1:0] RMRC_IDX_RATE = 4'h3;
    localparam logic [RMRC_ADDR_W-1:0] RMRC_IDX_FLOOR = 4'h4;
    localparam logic [RMRC_DATA_W-1:0] RMRC_RST_DMOD = 8'h88;
    localparam logic [RMRC_DATA_W-1:0] RMRC_RST_FDEV = 8'h03;
    localparam logic [RMRC_DATA_W-1:0] RMRC_RST_RATE = 8'h07;
    localparam logic [RMRC_DATA_W-1:0] RMRC_RST_FLOOR = 8'h0c;
    localparam logic [RMRC_DATA_W-1:0] RMRC_RATE_WMASK = 8'h7f;
    localparam int unsigned RMRC_MOD_HI = 7;
    localparam int unsigned RMRC_MOD_LO = 6;
    localparam int unsigned RMRC_DM_LOW_BIT = 5;
    localparam int unsigned RMRC_THR_HI = 4;
    localparam int unsigned RMRC_THR_LO = 3;
    localparam int unsigned RMRC_DM_HIGH_BIT = 2;
    localparam int unsigned RMRC_GAIN_HI = 1;
    localparam int unsigned RMRC_GAIN_LO = 0;
    localparam logic [1:0] RMRC_MOD_FSK = 2'h2;
    localparam logic [1:0] RMRC_MOD_OOK = 2'h1;
    localparam logic [1:0] RMRC_THR_FIXED = 2'h0;
    localparam logic [1:0] RMRC_THR_PEAK = 2'h1;
    localparam logic [1:0] RMRC_THR_AVG = 2'h2;
    localparam logic [1:0] RMRC_DMODE_CONT = 2'h0;
    localparam logic [1:0] RMRC_DMODE_BUF = 2'h1;
    localparam logic [1:0] RMRC_DMODE_PKT = 2'h2;
    localparam logic [31:0] RMRC_BAD_ADDR_DATA = 32'h0000_0000;
    localparam real RMRC_REF_XTAL_MHZ = 12.8;
    localparam int unsigned RMRC_FDEV_DIV = 32;
    localparam int unsigned RMRC_RATE_DIV = 64;
endpackage

/* File: dv/rmrc_regs_chk.sv */
`timescale 1ns/1ps
module rmrc_regs_chk (
    input wire logic ref_clk_i, // clock
    input wire logic reset_n_i, // reset
    input wire logic [5:0] avs_address_i, // address
    input wire logic avs_read_i, // read
    input wire logic avs_write_i, // write
    input wire logic [31:0] avs_writedata_i, // wdata
    input wire logic [3:0] avs_byteenable_i, // lanes
    input wire logic [31:0] avs_readdata_o, // rdata
    input wire logic avs_waitrequest_o, // stall
    input wire logic [1:0] modulation_select_o, // mod
    input wire logic [1:0] data_mode_o, // mode
    input wire logic [1:0] onoff_threshold_type_o, // thr
    input wire logic [1:0] intermediate_gain_step_o, // gain
    input wire logic [7:0] deviation_value_o, // dev
    input wire logic [6:0] rate_value_o, // rate
    input wire logic [7:0] onoff_floor_value_o // floor
);
    wire logic ack = !avs_waitrequest_o;
    wire logic [3:0] idx = avs_address_i[5:2];
    wire logic [7:0] rb = avs_readdata_o[7:0];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // lane 0 off means the write is answered but dropped
    sequence wr_taken;
        avs_write_i && ack && avs_byteenable_i[0];
    endsequence
    chk_ack_once: assert property (ack |=> !ack) else $error("ack held");
    chk_req_answer: assert property ((avs_read_i || avs_write_i) && !ack |=> ack)
        else $error("no answer");
    chk_dev_write: assert property (wr_taken ##0 idx == 4'h2
        |=> deviation_value_o == $past(avs_writedata_i[7:0])) else $error("dev write");
    chk_rate_write: assert property (wr_taken ##0 idx == 4'h3
        |=> rate_value_o == $past(avs_writedata_i[6:0])) else $error("rate write");
    chk_floor_write: assert property (wr_taken ##0 idx == 4'h4
        |=> onoff_floor_value_o == $past(avs_writedata_i[7:0])) else $error("floor write");
    chk_fields_hold: assert property (!(avs_write_i && !ack) |=>
        $stable({deviation_value_o, rate_value_o, onoff_floor_value_o})) else $error("drift");
    chk_dmod_read: assert property (avs_read_i && ack && idx == 4'h1 |->
        {rb[7:6], rb[4:3], rb[1:0]} == {modulation_select_o, onoff_threshold_type_o,
        intermediate_gain_step_o} && data_mode_o == (rb[2] ? 2'h2 : {1'b0, rb[5]}))
        else $error("mode readback");
    chk_bad_read: assert property (avs_read_i && ack && !(idx inside {[4'h1:4'h4]})
        |-> avs_readdata_o == 32'h0) else $error("unmapped read");
endmodule
bind rmrc_regs rmrc_regs_chk u_chk (.*);

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [5:0] avs_address_i = 6'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [1:0] modulation_select_o, data_mode_o, onoff_threshold_type_o, intermediate_gain_step_o;
    logic [7:0] deviation_value_o, onoff_floor_value_o, v;
    logic [6:0] rate_value_o;
    logic [8:0] e;
    logic avs_waitrequest_o, mod_reserved_o;
    int err_total = 0, compares = 0;
    wire logic [8:0] dmod_f = {mod_reserved_o, modulation_select_o, data_mode_o,
        onoff_threshold_type_o, intermediate_gain_step_o};
    rmrc_regs uut (.*);
    initial forever #2 ref_clk_i = ~ref_clk_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) err_total++;
        if (seen !== exp) $display("Error at %0t: saw %h want %h", $time, seen, exp);
    endtask
    // no cap on the wait here: the watchdog ends a hang
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
        input logic [3:0] b);
        @(posedge ref_clk_i);
        {avs_read_i, avs_write_i, avs_address_i, avs_byteenable_i, avs_writedata_i} <=
            {!w, w, a, b, 24'h0, d};
        // look between edges, then act on the edge that sees it low
        do @(negedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        @(posedge ref_clk_i);
        if (!w) check(avs_readdata_o, {24'h0, d});
        {avs_read_i, avs_write_i} <= 2'b00;
    endtask
    task automatic results;
        $display("Compares %0d, errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #4000;
        err_total++;
        results;
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        acc(1'b0, 6'h04, 8'h88, 4'hf);
        acc(1'b0, 6'h08, 8'h03, 4'hf);
        acc(1'b0, 6'h0c, 8'h07, 4'hf);
        acc(1'b0, 6'h10, 8'h0c, 4'hf);
        for (int k = 0; k < 4; k++) begin
            v = {k[1:0], k[0], k[1:0], k[1], k[1:0]};
            e = {k == 0 || k == 3, k[1:0], k[1] ? 2'h2 : {1'b0, k[0]}, k[1:0], k[1:0]};
            acc(1'b1, 6'h04, v, 4'h1);
            acc(1'b0, 6'h04, v, 4'hf);
            check({23'h0, dmod_f}, {23'h0, e});
        end
        acc(1'b1, 6'h08, 8'hff, 4'h1);
        acc(1'b1, 6'h0c, 8'h7f, 4'h1);
        acc(1'b1, 6'h10, 8'ha5, 4'h1);
        acc(1'b1, 6'h08, 8'h00, 4'h0);
        acc(1'b1, 6'h3c, 8'h5a, 4'h1);
        acc(1'b0, 6'h08, 8'hff, 4'hf);
        acc(1'b0, 6'h0c, 8'h7f, 4'hf);
        acc(1'b0, 6'h10, 8'ha5, 4'hf);
        acc(1'b0, 6'h3c, 8'h00, 4'hf);
        check({9'h0, rate_value_o, deviation_value_o, onoff_floor_value_o}, 32'h007fffa5);
        results;
    end
endmodule
